/* File: inc/eacd_cfg.svh */
// Purpose: Constants of the configuration word loader.
// Assumes: Included by its bare name after the package is compiled.
// Notes: Byte addresses are those of the Wishbone register window.
`ifndef EACD_CFG_SVH
`define EACD_CFG_SVH

// Configuration image layout, in 16-bit word addresses.
`define EACD_W_NODE0 3'h0
`define EACD_W_NODE1 3'h1
`define EACD_W_NODE2 3'h2
`define EACD_W_AUTO 3'h3
`define EACD_W_VID 3'h4
`define EACD_W_PID 3'h5
`define EACD_W_PIN 3'h6
`define EACD_W_WAKE 3'h7
`define EACD_W_LAST 3'h7
`define EACD_WORDS 8

// Gating fields of the auto-load control word.
`define EACD_G_ID 1:0
`define EACD_G_PIN 3:2
`define EACD_G_WAKE 7:6
`define EACD_G_LED 11:10
`define EACD_G_PHY 13:12
`define EACD_G_XOVER 15:14
`define EACD_G_ON 2'h1

// Bits of the wake-up and pin words that each gate releases.
`define EACD_M_WAKE 16'h000F
`define EACD_M_LED 16'h0080
`define EACD_M_PHY 16'h0100
`define EACD_M_XOVER 16'h4000
`define EACD_M_PIN 9'h1FF
`define EACD_M_NONE16 16'h0000
`define EACD_M_NONE9 9'h000

// Fields of the effective pin and wake-up settings.
`define EACD_P_CS 0
`define EACD_P_RD 1
`define EACD_P_WR 2
`define EACD_P_INTPOL 3
`define EACD_P_INTOD 4
`define EACD_P_WAITPOL 5
`define EACD_P_WAITOD 6
`define EACD_P_BWPOL 7
`define EACD_P_BWOD 8
`define EACD_K_WAKEPOL 0
`define EACD_K_PULSE 1
`define EACD_K_MAGIC 2
`define EACD_K_LINK 3
`define EACD_K_LED 7
`define EACD_K_PHY 8
`define EACD_K_XOVER 14

// Built-in defaults, used when neither the image nor a strap decides.
`define EACD_DEF_STROBE_LOW 1'b1
`define EACD_DEF_INT_OD 1'b1
`define EACD_DEF_WAIT_LOW 1'b0
`define EACD_DEF_WAIT_OD 1'b0
`define EACD_DEF_BW_LOW 1'b0
`define EACD_DEF_BW_OD 1'b0
`define EACD_DEF_WAKE 16'h4180
// Pin settings held in reset: select and strobes active low, rest zero.
`define EACD_RST_PIN 9'h007
// Identification defaults; the values are arbitrary.
`define EACD_DEF_VID 16'h1234
`define EACD_DEF_PID 16'h5678

// Last count of the strap settle wait, which lasts four cycles after reset or reload.
`define EACD_SETTLE 2'h3

// Register window, byte addresses.
`define EACD_A_CTRL 8'h00
`define EACD_A_MAC_LO 8'h04
`define EACD_A_MAC_HI 8'h08
`define EACD_A_IDS 8'h0C
`define EACD_A_PIN 8'h10
`define EACD_A_WAKE 8'h14
`define EACD_A_AUTO 8'h18
`define EACD_GPR_INDEX 6'h1F
`define EACD_B_RELOAD 0
`define EACD_B_BUSY 0
`define EACD_B_DONE 1
`define EACD_B_GPR_PD 0

`endif

/* File: inc/eacd_pkg.sv */
// Purpose: Types of the configuration word loader.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Numeric constants live in eacd_cfg.svh.
package eacd_pkg;

  typedef logic [15:0] eacd_word_t;

  typedef enum logic [2:0] {
    EACD_ST_SETTLE,
    EACD_ST_FETCH,
    EACD_ST_NEXT,
    EACD_ST_APPLY,
    EACD_ST_IDLE
  } eacd_state_t;

endpackage : eacd_pkg

/* File: design/eacd_loader.sv */
// Purpose: Loads and decodes the configuration words of the serial
//   configuration memory after power-on reset and holds the settings.
// Assumes: A word reader on mclk returns one 16-bit word per request.
// Notes: Straps are pins and pass a two-stage synchroniser.
//   Reserved image bits are masked off; a bad image is not flagged.
//
// Overview of operation
// R1 - Words 0 to 2 give the six-byte station address.
// R2 - Word 3 bits 1:0 equal 01 loads the identification words.
// R3 - Word 3 bits 3:2 equal 01 applies word 6 bits 8:0.
// R4 - Word 3 bits 7:6 equal 01 applies word 7 bits 3:0.
// R5 - Word 3 bits 11:10 equal 01 applies the LED mode bit.
// R6 - Word 3 bits 13:12 equal 01 applies the PHY power-up bit.
// R7 - Word 3 bits 15:14 equal 01 applies word 7 bits 15:12; the code applies word 7 bit 14 only.
// R8 - The memory holds zero in every reserved field.
// R9 - Word 6 sets pin polarity and type only when enabled.
// R10 - Word 6 bits 0 to 2 set select and strobe polarity.
// R11 - Word 6 bits 3 and 4 set interrupt polarity and type.
// R12 - Word 6 bits 5 and 6 set wait output polarity and type.
// R13 - Word 6 bits 7 and 8 set width indicator polarity and type.
// R14 - Each word 7 field applies only when its gate enables it.
// R15 - Word 7 bits 0 and 1 set wake polarity and pulse mode.
// R16 - Word 7 bits 2 and 3 enable magic packet and link wake-up.
// R17 - Word 7 bit 7 selects LED mode 0 or 1.
// R18 - Word 7 bit 8 leaves the internal PHY off or on.
// R19 - General purpose register bit 0 follows loaded word 7 bit 8.
// R20 - Word 7 bit 14 turns automatic crossover off or on.
// R21 - Sample word values are reference only, not mandatory.
// R22 - All settings are read after hardware power-on reset.
// R23 - Enabled image setting beats strap, strap beats default; the code uses the open-drain strap only when the 8-bit strap is set.
// R24 - Every access is a whole word at a word address.
// R25 - A gate not holding 01 keeps strap or default values.

`include "eacd_cfg.svh"

module eacd_loader
  import eacd_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ee_rd_req,
  output logic [5:0] ee_word_addr,
  input wire logic ee_rd_valid,
  input wire logic [15:0] ee_rd_data,
  input wire logic strap_int_active_low,
  input wire logic strap_bus_8bit,
  input wire logic strap_int_open_drain,
  output logic load_busy,
  output logic load_done,
  output logic [47:0] station_addr,
  output logic [15:0] vendor_id,
  output logic [15:0] product_id,
  output logic cs_active_low,
  output logic read_strobe_active_low,
  output logic write_strobe_active_low,
  output logic int_active_low,
  output logic int_open_drain,
  output logic wait_output_active_low,
  output logic wait_output_open_drain,
  output logic bus_width_indicator_active_low,
  output logic bus_width_indicator_open_drain,
  output logic wake_active_low,
  output logic wake_pulse_mode,
  output logic wake_magic_en,
  output logic wake_link_en,
  output logic led_mode1,
  output logic phy_enable,
  output logic phy_power_down,
  output logic automatic_crossover_en
);

  function automatic logic gate_on(input logic [1:0] field);
    gate_on = (field == `EACD_G_ON);
  endfunction : gate_on

  // Masked bits come from the image; the rest keep the fallback value.
  function automatic eacd_word_t merge_masked(input eacd_word_t fallback,
    input eacd_word_t image, input eacd_word_t mask);
    merge_masked = (fallback & ~mask) | (image & mask);
  endfunction : merge_masked

  eacd_state_t state_r;
  eacd_state_t state_nxt;
  eacd_word_t words_r [`EACD_WORDS];
  logic [2:0] word_idx_r;
  logic [1:0] settle_r;
  logic req_r;
  logic done_r;
  logic [1:0] strap_pol_sync_r;
  logic [1:0] strap_bus_sync_r;
  logic [1:0] strap_od_sync_r;
  logic strap_pol_r;
  logic strap_bus8_r;
  logic strap_od_r;
  logic [47:0] station_r;
  logic [15:0] vid_r;
  logic [15:0] pid_r;
  logic [8:0] pin_cfg_r;
  logic [15:0] wake_cfg_r;
  logic gpr_pd_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic busy_r;

  // Wishbone decode.
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == `EACD_A_CTRL);
  wire hit_mac_lo = (wb_adr_i == `EACD_A_MAC_LO);
  wire hit_mac_hi = (wb_adr_i == `EACD_A_MAC_HI);
  wire hit_ids = (wb_adr_i == `EACD_A_IDS);
  wire hit_pin = (wb_adr_i == `EACD_A_PIN);
  wire hit_wake = (wb_adr_i == `EACD_A_WAKE);
  wire hit_auto = (wb_adr_i == `EACD_A_AUTO);
  wire hit_gpr = (wb_adr_i == {`EACD_GPR_INDEX, 2'h0});
  wire reload_cmd = bus_wr && hit_ctrl && wb_sel_i[0]
    && wb_dat_i[`EACD_B_RELOAD];
  wire gpr_wr = bus_wr && hit_gpr && wb_sel_i[0];

  // Reload is only honoured while idle, so a running load is not cut.
  wire reload_go = reload_cmd && (state_r == EACD_ST_IDLE);

  // Read data is registered with ack and is zero outside an ack cycle.
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, done_r, state_r != EACD_ST_IDLE} :
    hit_mac_lo ? station_r[31:0] :
    hit_mac_hi ? {16'h0, station_r[47:32]} :
    hit_ids ? {pid_r, vid_r} :
    hit_pin ? {23'h0, pin_cfg_r} :
    hit_wake ? {16'h0, wake_cfg_r} :
    hit_auto ? {16'h0, words_r[`EACD_W_AUTO]} :
    hit_gpr ? {31'h0, gpr_pd_r} : 32'h0;

  // Gating decode of the auto-load control word.
  wire eacd_word_t auto_w = words_r[`EACD_W_AUTO];
  wire eacd_word_t wake_w = words_r[`EACD_W_WAKE];
  wire eacd_word_t pin_w = words_r[`EACD_W_PIN];
  wire id_on = gate_on(auto_w[`EACD_G_ID]); // [R2]
  wire pin_on = gate_on(auto_w[`EACD_G_PIN]); // [R3] [R9]
  wire wake_on = gate_on(auto_w[`EACD_G_WAKE]); // [R4]
  wire led_on = gate_on(auto_w[`EACD_G_LED]); // [R5]
  wire phy_on = gate_on(auto_w[`EACD_G_PHY]); // [R6]
  wire xover_on = gate_on(auto_w[`EACD_G_XOVER]); // [R7]

  // A closed identification gate restores the defaults, so a reload
  // never keeps the identifiers of an earlier image.
  wire eacd_word_t vid_next = id_on ? words_r[`EACD_W_VID]
    : `EACD_DEF_VID; // [R2] [R25]
  wire eacd_word_t pid_next = id_on ? words_r[`EACD_W_PID]
    : `EACD_DEF_PID; // [R2] [R25]
  // Byte 0 of the station address is the low byte of word 0.
  wire [47:0] station_next = {words_r[`EACD_W_NODE2],
    words_r[`EACD_W_NODE1], words_r[`EACD_W_NODE0]}; // [R1]

  // Only the documented bits pass a mask; reserved bits never reach
  // the settings, so a careless image cannot switch anything hidden.
  wire [15:0] wake_mask =
    (wake_on ? `EACD_M_WAKE : `EACD_M_NONE16) |
    (led_on ? `EACD_M_LED : `EACD_M_NONE16) |
    (phy_on ? `EACD_M_PHY : `EACD_M_NONE16) |
    (xover_on ? `EACD_M_XOVER : `EACD_M_NONE16); // [R14] [R8]
  wire [8:0] pin_mask = pin_on ? `EACD_M_PIN : `EACD_M_NONE9;

  // Strap level beats the built-in default, the open-drain strap only when the 8-bit strap is set; the image beats both.
  wire strap_int_od_eff = strap_bus8_r ? strap_od_r
    : `EACD_DEF_INT_OD; // [R23]
  wire [8:0] pin_default = {
    `EACD_DEF_BW_OD, `EACD_DEF_BW_LOW,
    `EACD_DEF_WAIT_OD, `EACD_DEF_WAIT_LOW,
    strap_int_od_eff, strap_pol_r,
    `EACD_DEF_STROBE_LOW, `EACD_DEF_STROBE_LOW, `EACD_DEF_STROBE_LOW
  };
  wire eacd_word_t pin_merged = merge_masked({7'h00, pin_default}, pin_w,
    {7'h00, pin_mask}); // [R23] [R25] [R10] [R11] [R12] [R13]
  wire [8:0] pin_next = pin_merged[8:0];
  wire [15:0] wake_next = merge_masked(`EACD_DEF_WAKE, wake_w,
    wake_mask); // [R25] [R15] [R16] [R17] [R18] [R20]
  wire last_word = (word_idx_r == `EACD_W_LAST);
  wire store_word = (state_r == EACD_ST_FETCH) && ee_rd_valid;
  wire apply_now = (state_r == EACD_ST_APPLY);

  // The settle wait lets the strap synchronisers fill before the straps
  // are caught, and then the eight words are fetched one at a time.

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EACD_ST_SETTLE: begin
        if (settle_r == `EACD_SETTLE) begin
          state_nxt = EACD_ST_FETCH;
        end
      end
      EACD_ST_FETCH: begin
        if (ee_rd_valid) begin
          state_nxt = last_word ? EACD_ST_APPLY : EACD_ST_NEXT;
        end
      end
      EACD_ST_NEXT: state_nxt = EACD_ST_FETCH;
      EACD_ST_APPLY: state_nxt = EACD_ST_IDLE;
      EACD_ST_IDLE: begin
        if (reload_go) begin
          state_nxt = EACD_ST_SETTLE;
        end
      end
      default: state_nxt = EACD_ST_SETTLE;
    endcase
  end

  // Strap synchronisers; only the second stage is read.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_pol_sync_r <= 2'h0;
      strap_bus_sync_r <= 2'h0;
      strap_od_sync_r <= 2'h0;
    end else begin
      strap_pol_sync_r <= {strap_pol_sync_r[0], strap_int_active_low};
      strap_bus_sync_r <= {strap_bus_sync_r[0], strap_bus_8bit};
      strap_od_sync_r <= {strap_od_sync_r[0], strap_int_open_drain};
    end
  end

  // Load sequencer: starts by itself after reset release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= EACD_ST_SETTLE; // [R22]
      settle_r <= 2'h0;
      word_idx_r <= `EACD_W_NODE0;
      req_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        EACD_ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          word_idx_r <= `EACD_W_NODE0;
          req_r <= (settle_r == `EACD_SETTLE);
        end
        EACD_ST_FETCH: begin
          if (ee_rd_valid) begin
            req_r <= 1'b0;
          end
        end
        EACD_ST_NEXT: begin
          word_idx_r <= word_idx_r + 3'h1;
          req_r <= 1'b1;
        end
        EACD_ST_APPLY: done_r <= 1'b1;
        EACD_ST_IDLE: begin
          settle_r <= 2'h0;
          if (reload_go) begin
            done_r <= 1'b0;
          end
        end
        default: req_r <= 1'b0;
      endcase
    end
  end

  // Whole words are stored as they arrive, one per request.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `EACD_WORDS; i++) begin
        words_r[i] <= 16'h0000;
      end
    end else if (store_word) begin
      words_r[word_idx_r] <= ee_rd_data; // [R24]
    end
  end

  // Straps are caught while the synchronisers have settled.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_pol_r <= 1'b0;
      strap_bus8_r <= 1'b0;
      strap_od_r <= 1'b0;
    end else if (state_r == EACD_ST_SETTLE
      && settle_r == `EACD_SETTLE) begin
      strap_pol_r <= strap_pol_sync_r[1];
      strap_bus8_r <= strap_bus_sync_r[1];
      strap_od_r <= strap_od_sync_r[1];
    end
  end

  // Settings update together at the end of a load, so the pins never
  // see a mix of old and new polarities.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      station_r <= 48'h0;
      vid_r <= `EACD_DEF_VID;
      pid_r <= `EACD_DEF_PID;
    end else if (apply_now) begin
      station_r <= station_next; // [R1]
      vid_r <= vid_next; // [R2]
      pid_r <= pid_next; // [R2]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_cfg_r <= `EACD_RST_PIN;
      wake_cfg_r <= `EACD_DEF_WAKE;
    end else if (apply_now) begin
      pin_cfg_r <= pin_next; // [R9]
      wake_cfg_r <= wake_next; // [R14]
    end
  end

  // The power-down bit is the inverse of the PHY enable; software may
  // overwrite it once the load is done, and a later load wins.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gpr_pd_r <= 1'b0;
    end else if (apply_now) begin
      gpr_pd_r <= !wake_next[`EACD_K_PHY]; // [R19]
    end else if (gpr_wr) begin
      gpr_pd_r <= wb_dat_i[`EACD_B_GPR_PD];
    end
  end

  // One wait state: ack one cycle after the request, then dropped.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= bus_req;
      dat_r <= bus_req ? rd_mux : 32'h0;
    end
  end

  // Busy is taken from the next state, so the port is a plain flop
  // output with the same timing as a decode of the state register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b1;
    end else begin
      busy_r <= (state_nxt != EACD_ST_IDLE);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign ee_rd_req = req_r;
  assign ee_word_addr = {3'h0, word_idx_r}; // [R24]
  assign load_busy = busy_r;
  assign load_done = done_r;
  assign station_addr = station_r;
  assign vendor_id = vid_r;
  assign product_id = pid_r;
  assign cs_active_low = pin_cfg_r[`EACD_P_CS];
  assign read_strobe_active_low = pin_cfg_r[`EACD_P_RD];
  assign write_strobe_active_low = pin_cfg_r[`EACD_P_WR];
  assign int_active_low = pin_cfg_r[`EACD_P_INTPOL];
  assign int_open_drain = pin_cfg_r[`EACD_P_INTOD];
  assign wait_output_active_low = pin_cfg_r[`EACD_P_WAITPOL];
  assign wait_output_open_drain = pin_cfg_r[`EACD_P_WAITOD];
  assign bus_width_indicator_active_low = pin_cfg_r[`EACD_P_BWPOL];
  assign bus_width_indicator_open_drain = pin_cfg_r[`EACD_P_BWOD];
  assign wake_active_low = wake_cfg_r[`EACD_K_WAKEPOL];
  assign wake_pulse_mode = wake_cfg_r[`EACD_K_PULSE];
  assign wake_magic_en = wake_cfg_r[`EACD_K_MAGIC];
  assign wake_link_en = wake_cfg_r[`EACD_K_LINK];
  assign led_mode1 = wake_cfg_r[`EACD_K_LED];
  assign phy_enable = wake_cfg_r[`EACD_K_PHY];
  assign phy_power_down = gpr_pd_r;
  assign automatic_crossover_en = wake_cfg_r[`EACD_K_XOVER];

endmodule : eacd_loader

/* File: verification/eacd_loader_properties.sv */
// Purpose: Concurrent checks on the ports of the configuration loader.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Words 3 and 6 are captured as they pass on the word link.
`include "eacd_cfg.svh"

module eacd_loader_chk
  import eacd_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ee_rd_req,
  input wire logic ee_rd_valid,
  input wire logic [5:0] ee_word_addr,
  input wire logic [15:0] ee_rd_data,
  input wire logic load_busy,
  input wire logic load_done,
  input wire logic [15:0] vendor_id,
  input wire logic [15:0] product_id,
  input wire logic cs_active_low,
  input wire logic int_open_drain,
  input wire logic bus_width_indicator_open_drain,
  input wire logic led_mode1,
  input wire logic phy_enable,
  input wire logic phy_power_down,
  input wire logic automatic_crossover_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w3_r;
  logic [8:0] w6_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      w3_r <= 16'h0000;
      w6_r <= 9'h000;
    end else if (ee_rd_req && ee_rd_valid) begin
      if (ee_word_addr == 6'h03) w3_r <= ee_rd_data;
      if (ee_word_addr == 6'h06) w6_r <= ee_rd_data[8:0];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  chk_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o) else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_word_held: assert property (
    (ee_rd_req && !ee_rd_valid) |=> ee_rd_req && $stable(ee_word_addr))
    else $error("word request not held");
  chk_word_order: assert property (
    (ee_rd_req && ee_rd_valid && ee_word_addr < 6'h07) |=> !ee_rd_req
    ##1 (ee_rd_req && ee_word_addr == $past(ee_word_addr, 2) + 6'h01))
    else $error("word order or spacing wrong");
  chk_idle_quiet: assert property (!load_busy |-> !ee_rd_req)
    else $error("word request while idle");
  chk_done_end: assert property ($fell(load_busy) |-> load_done)
    else $error("load end without done");
  chk_gpr_follow: assert property ($fell(load_busy)
    |-> phy_power_down == !phy_enable) else $error("power-down mismatch");
  chk_id_gate: assert property (($fell(load_busy)
    && w3_r[1:0] != 2'h1) |-> vendor_id == `EACD_DEF_VID
    && product_id == `EACD_DEF_PID) else $error("ids loaded while gated");
  chk_pin_gate: assert property (($fell(load_busy)
    && w3_r[3:2] == 2'h1) |-> cs_active_low == w6_r[0]
    && int_open_drain == w6_r[4]
    && bus_width_indicator_open_drain == w6_r[8])
    else $error("pin settings differ from word 6");
  chk_hold_steady: assert property (
    (!load_busy && !$fell(load_busy)) |-> $stable({vendor_id, product_id,
    cs_active_low, led_mode1, phy_enable, automatic_crossover_en}))
    else $error("settings moved outside a load");
endmodule : eacd_loader_chk

bind eacd_loader eacd_loader_chk chk_u (
  .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ee_rd_req(ee_rd_req), .ee_rd_valid(ee_rd_valid),
  .ee_word_addr(ee_word_addr), .ee_rd_data(ee_rd_data),
  .load_busy(load_busy), .load_done(load_done), .vendor_id(vendor_id),
  .product_id(product_id), .cs_active_low(cs_active_low),
  .int_open_drain(int_open_drain),
  .bus_width_indicator_open_drain(bus_width_indicator_open_drain),
  .led_mode1(led_mode1), .phy_enable(phy_enable),
  .phy_power_down(phy_power_down),
  .automatic_crossover_en(automatic_crossover_en)
);

/* File: verification/eacd_word_rom.sv */
// Purpose: Behavioural configuration memory behind the word reader.
// Assumes: One whole 16-bit word answers each request.
// Notes: Data shows changing junk outside the valid pulse.
module eacd_word_rom (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ee_rd_req,
  input wire logic [5:0] ee_word_addr,
  output logic ee_rd_valid,
  output logic [15:0] ee_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [8];
  int lat = 0;
  int cnt = 0;
  initial ee_rd_valid = 1'b0;
  initial ee_rd_data = 16'hA5A5;

  always @(posedge mclk) begin
    if (!resetn || !ee_rd_req || ee_rd_valid || cnt < lat) begin
      ee_rd_valid <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      cnt <= (ee_rd_req && !ee_rd_valid && resetn) ? cnt + 1 : 0;
    end else begin
      ee_rd_valid <= 1'b1;
      ee_rd_data <= mem[ee_word_addr[2:0]];
    end
  end
endmodule : eacd_word_rom

/* File: verification/testbench.sv */
// Purpose: Self-checking bench of the configuration word loader.
// Assumes: The memory model answers every word request.
// Notes: Four images cover each gate set and cleared, two loaded by reset and two by reload.
`include "eacd_cfg.svh"

module testbench;
  import eacd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic s_pol = 0, s_b8 = 0, s_od = 1, ack, req, vld, busy, done, pd;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0, q, dat_o;
  logic [5:0] wa;
  logic [15:0] rd, vid, pid;
  logic [47:0] sta, ex;
  wire [8:0] pin;
  wire [6:0] wk;
  int n_fail = 0, total_checks = 0, cycles = 0;
  // Reserved fields stay zero; image 0 uses the sample values.
  logic [15:0] w3s [4] = '{16'h5445, 16'h0000, 16'h1004, 16'h0000};
  logic [15:0] w6s [4] = '{16'h01E7, 16'h01FF, 16'h0118, 16'h01FF};
  logic [15:0] w7s [4] = '{16'h408F, 16'h000F, 16'h000F, 16'h000F};

  eacd_loader dut_u (
    .mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ee_rd_req(req),
    .ee_word_addr(wa), .ee_rd_valid(vld), .ee_rd_data(rd),
    .strap_int_active_low(s_pol), .strap_bus_8bit(s_b8),
    .strap_int_open_drain(s_od), .load_busy(busy), .load_done(done),
    .station_addr(sta), .vendor_id(vid), .product_id(pid),
    .cs_active_low(pin[0]), .read_strobe_active_low(pin[1]),
    .write_strobe_active_low(pin[2]), .int_active_low(pin[3]),
    .int_open_drain(pin[4]), .wait_output_active_low(pin[5]),
    .wait_output_open_drain(pin[6]),
    .bus_width_indicator_active_low(pin[7]),
    .bus_width_indicator_open_drain(pin[8]), .wake_active_low(wk[0]),
    .wake_pulse_mode(wk[1]), .wake_magic_en(wk[2]), .wake_link_en(wk[3]),
    .led_mode1(wk[4]), .phy_enable(wk[5]), .phy_power_down(pd),
    .automatic_crossover_en(wk[6])
  );
  eacd_word_rom rom_u (.mclk(mclk), .resetn(resetn), .ee_rd_req(req),
    .ee_word_addr(wa), .ee_rd_valid(vld), .ee_rd_data(rd));

  initial forever #12.5 mclk = ~mclk;

  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic cycle: request held until the edge that samples ack.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dw <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    wb(1'b0, a, 4'h0, 32'h0);
    chk(nm, e, q);
  endtask : rdc

  function automatic logic [15:0] img(int i, int k);
    case (k)
      3: return w3s[i];
      4: return 16'h00A0 + 16'(i);
      5: return 16'h00B0 + 16'(i);
      6: return w6s[i];
      7: return w7s[i];
      default: return 16'h1100 * 16'(k + 1) + 16'(i);
    endcase
  endfunction : img

  initial begin
    logic [15:0] e7, w3;
    logic [31:0] ids;
    logic [8:0] e6;
    repeat (12) @(posedge mclk);
    chk("reset", 3'h4, {busy, done, pd});
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) rom_u.mem[k] = img(i, k);
      rom_u.lat = i;
      s_pol <= (i == 1);
      s_b8 <= (i == 1);
      s_od <= (i == 0);
      if (i == 0) resetn <= 1'b1;
      else if (i == 2) begin
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
      end else wb(1'b1, `EACD_A_CTRL, 4'h1, 32'h1);
      while (busy !== 1'b1) @(posedge mclk);
      while (busy !== 1'b0) @(posedge mclk);
      @(posedge mclk);
      w3 = w3s[i];
      e6 = {`EACD_DEF_BW_OD, `EACD_DEF_BW_LOW, `EACD_DEF_WAIT_OD,
            `EACD_DEF_WAIT_LOW, s_b8 ? s_od : `EACD_DEF_INT_OD, s_pol,
            {3{`EACD_DEF_STROBE_LOW}}};
      if (w3[3:2] == 2'h1) e6 = w6s[i][8:0];
      e7 = 16'h4180;
      if (w3[7:6] == 2'h1) e7[3:0] = w7s[i][3:0];
      if (w3[11:10] == 2'h1) e7[7] = w7s[i][7];
      if (w3[13:12] == 2'h1) e7[8] = w7s[i][8];
      if (w3[15:14] == 2'h1) e7[14] = w7s[i][14];
      ids = {`EACD_DEF_PID, `EACD_DEF_VID};
      if (w3[1:0] == 2'h1) ids = {img(i, 5), img(i, 4)};
      ex = {img(i, 2), img(i, 1), img(i, 0)};
      chk("station", ex, sta);
      chk("ids", ids, {pid, vid});
      chk("pins", e6, pin);
      chk("wake", {e7[14], e7[8:7], e7[3:0]}, wk);
      chk("gpr", !e7[8], pd);
      rdc(`EACD_A_MAC_LO, ex[31:0], "mac_lo");
      rdc(`EACD_A_MAC_HI, {16'h0000, ex[47:32]}, "mac_hi");
      rdc(`EACD_A_IDS, ids, "ids_reg");
      rdc(`EACD_A_PIN, {23'h0, e6}, "pin_reg");
      rdc(`EACD_A_WAKE, {16'h0000, e7}, "wake_reg");
      rdc(`EACD_A_AUTO, {16'h0000, w3}, "auto_reg");
      rdc(`EACD_A_CTRL, 32'h2, "ctrl");
      rdc(8'h7C, {31'h0, ~e7[8]}, "gpr_reg");
    end
    wb(1'b1, `EACD_A_MAC_LO, 4'hF, 32'hFFFFFFFF);
    rdc(`EACD_A_MAC_LO, ex[31:0], "mac_ro");
    rdc(8'h40, 32'h0, "unmapped");
    wb(1'b1, 8'h7C, 4'h1, 32'h1);
    wb(1'b1, 8'h7C, 4'hE, 32'h0);
    rdc(8'h7C, 32'h1, "gpr_sel");
    chk("gpr_pin", 1'b1, pd);
    complete_run();
  end
endmodule : testbench
